// ### shared/card_host_pkg.sv
/*
  Shared constants and carriers of the card host register slice:
  special-function register addresses, event flag bit positions,
  reset values and the packed structs that carry register requests, engine events and FIFO levels.
  Assumes an 8-bit special-function register space.
*/
package card_host_pkg;

  // ************************************************************
  // Register addresses in special-function register space
  // ************************************************************
  localparam logic [7:0] ADDR_DATA_PORT    = 8'hdc;
  localparam logic [7:0] ADDR_COMMAND_PORT = 8'hdd;
  localparam logic [7:0] ADDR_EVENT_MASK   = 8'hdf;
  localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'he7;
  localparam logic [7:0] ADDR_CLOCK_DIV    = 8'hed;

  // ************************************************************
  // Event flag and mask bit positions
  // ************************************************************
  localparam int BIT_CARD_BUSY     = 7;
  localparam int BIT_RESPONSE_DONE = 6;
  localparam int BIT_COMMAND_DONE  = 5;
  localparam int BIT_FRAME_DONE    = 4;
  localparam int BIT_SECOND_FULL   = 3;
  localparam int BIT_FIRST_FULL    = 2;
  localparam int BIT_SECOND_EMPTY  = 1;
  localparam int BIT_FIRST_EMPTY   = 0;
  localparam int EVENT_COUNT       = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] MASK_RESET      = 8'hff;
  localparam logic [7:0] PORT_RESET      = 8'hff;
  localparam logic [7:0] FLAGS_RESET     = 8'h00;
  localparam logic [7:0] DIVIDER_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;
  localparam logic [7:0] COUNT_ZERO      = 8'h00;
  localparam logic [7:0] COUNT_STEP      = 8'h01;

  // Software access toward the register slice, one cycle wide.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_s;

  // One-cycle completion strobes from the command and data engines.
  typedef struct packed {
    logic response_done;
    logic command_done;
    logic frame_done;
  } engine_events_s;

  // Live levels of the two data FIFOs; index 0 is the first FIFO.
  typedef struct packed {
    logic [1:0] full;
    logic [1:0] empty;
  } fifo_levels_s;

endpackage : card_host_pkg

// ### logic/two_entry_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  The head entry drives the output directly, so out_data and
  out_valid come from flip-flops. Assumes a single clock domain.
*/
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  // Only the head-plus-spare structure is built.
  initial
  begin
    if (DEPTH != 2 || WIDTH < 1)
      $error("two_entry_buffer supports DEPTH 2 and WIDTH of at least 1");
  end

  logic [WIDTH-1:0] spare_q;
  logic             spare_valid_q;
  logic             push;
  logic             pop;

  // Ready is the spare slot being free, so no word is ever overwritten.
  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;

  // Head and spare move together; a pop refills the head from the spare.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_data      <= '0;
      out_valid     <= 1'b0;
      spare_q       <= '0;
      spare_valid_q <= 1'b0;
      in_ready      <= 1'b1;
    end
    else if (pop)
    begin
      if (spare_valid_q)
      begin
        out_data      <= spare_q;
        spare_valid_q <= 1'b0;
        in_ready      <= 1'b1;
      end
      else if (push)
        out_data <= in_data;
      else
        out_valid <= 1'b0;
    end
    else if (push)
    begin
      if (!out_valid)
      begin
        out_data  <= in_data;
        out_valid <= 1'b1;
      end
      else
      begin
        spare_q       <= in_data;
        spare_valid_q <= 1'b1;
        in_ready      <= 1'b0;
      end
    end
  end

endmodule : two_entry_buffer

// ### logic/card_host_irq_fifo_regs.sv
/*
  Register slice of the card host controller: event flags and mask,
  the command and data FIFO access ports and the card clock divider.
  Assumes a special-function register port on the peripheral clock,
  engine strobes and FIFO levels on that clock, and a busy level that
  comes straight from the card data pin.
*/
// Function
// [R1] Busy flag bit 7 sets on each busy edge, clears on flag read.
// [R2] Response-done flag bit 6 sets at response end, clears on flag read.
// [R3] Command-done flag bit 5 sets at command end, clears on flag read.
// [R4] Frame-done flag bit 4 sets at transfer end, clears on flag read.
// [R5] Second-full flag bit 3 sets when full, drops when that FIFO empties.
// [R6] First-full flag bit 2 sets when full, drops when that FIFO empties.
// [R7] Second-empty flag bit 1 sets when empty, drops when that FIFO fills.
// [R8] First-empty flag bit 0 sets when empty, drops when that FIFO fills.
// [R9] A flag reaches the interrupt only when its mask bit is zero; mask resets ones.
// [R10] Writing the command register pushes the byte toward the command FIFO.
// [R11] Reading the command register returns the next response FIFO byte.
// [R12] Data register writes enqueue transmit bytes, reads dequeue received bytes.
// [R13] An 8-bit divider register sets the card clock frequency.
// [R14] Clock and controller run only while the clock enable is set.
// [R15] Busy status mirrors the card busy line; its edges set the busy flag.
// [R16] Interrupt is OR of all flags each ANDed with its inverted mask.
// [R17] Card clock divides the peripheral clock: half period is divider plus one.
`timescale 1ns/1ns
module card_host_irq_fifo_regs #(
  parameter int          DATA_WIDTH    = 8,
  parameter logic [7:0]  DIVIDER_START = card_host_pkg::DIVIDER_RESET
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire card_host_pkg::sfr_req_s       sfr_req,
  output logic                [7:0]          sfr_rdata,
  input  wire logic                          controller_clock_enable,
  input  wire logic                          card_busy_pin,
  input  wire card_host_pkg::engine_events_s engine_events,
  input  wire card_host_pkg::fifo_levels_s   fifo_levels,
  output logic                [7:0]          command_byte,
  output logic                               command_valid,
  input  wire logic                          command_ready,
  output logic                               command_space,
  input  wire logic           [7:0]          response_byte,
  output logic                               response_pop,
  output logic                [7:0]          data_byte,
  output logic                               data_valid,
  input  wire logic                          data_ready,
  output logic                               data_space,
  input  wire logic           [7:0]          receive_byte,
  output logic                               receive_pop,
  output logic                               card_busy_status,
  output logic                               card_clock,
  output logic                               controller_irq
);

  initial
  begin
    if (DATA_WIDTH != 8)
      $error("card_host_irq_fifo_regs serves 8-bit register data only");
  end

  // ************************************************************
  // Register access decode
  // ************************************************************

  logic wr_data;
  logic wr_command;
  logic wr_mask;
  logic wr_divider;
  logic rd_data;
  logic rd_command;
  logic rd_flags;

  // Each strobe is one cycle wide, so each decode is a one-cycle pulse.
  always_comb
  begin
    wr_data    = 1'b0;
    wr_command = 1'b0;
    wr_mask    = 1'b0;
    wr_divider = 1'b0;
    if (sfr_req.wr)
    begin
      if (sfr_req.addr == card_host_pkg::ADDR_DATA_PORT)
        wr_data = 1'b1;
      else if (sfr_req.addr == card_host_pkg::ADDR_COMMAND_PORT)
        wr_command = 1'b1;
      else if (sfr_req.addr == card_host_pkg::ADDR_EVENT_MASK)
        wr_mask = 1'b1;
      else if (sfr_req.addr == card_host_pkg::ADDR_CLOCK_DIV)
        wr_divider = 1'b1;
    end
  end

  // Read decode is kept apart so a read never looks like a write.
  always_comb
  begin
    rd_data    = 1'b0;
    rd_command = 1'b0;
    rd_flags   = 1'b0;
    if (sfr_req.rd)
    begin
      if (sfr_req.addr == card_host_pkg::ADDR_DATA_PORT)
        rd_data = 1'b1;
      else if (sfr_req.addr == card_host_pkg::ADDR_COMMAND_PORT)
        rd_command = 1'b1;
      else if (sfr_req.addr == card_host_pkg::ADDR_EVENT_FLAGS)
        rd_flags = 1'b1;
    end
  end

  // ************************************************************
  // Mask and divider registers
  // ************************************************************

  logic [7:0] mask_q;
  logic [7:0] divider_q;

  // Every source starts masked so no stray event interrupts at start-up.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_q <= card_host_pkg::MASK_RESET; // [R9]
    else if (wr_mask)
      mask_q <= sfr_req.wdata;
  end

  // The divider may be rewritten at any time; the new value takes
  // effect at once, since the running count is compared with it every cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      divider_q <= DIVIDER_START;
    else if (wr_divider)
      divider_q <= sfr_req.wdata; // [R13]
  end

  // ************************************************************
  // Card busy line synchroniser
  // ************************************************************

  logic busy_meta_q;
  logic busy_sync_q;
  logic busy_edge;

  // Two flip-flops before any logic; the status flop is the third stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_meta_q      <= 1'b0;
      busy_sync_q      <= 1'b0;
      card_busy_status <= 1'b0;
    end
    else
    begin
      busy_meta_q      <= card_busy_pin;
      busy_sync_q      <= busy_meta_q;
      card_busy_status <= busy_sync_q; // [R15]
    end
  end

  // Entry into and exit from busy both count as events.
  assign busy_edge = busy_sync_q ^ card_busy_status; // [R15]

  // ************************************************************
  // Event flags
  // ************************************************************

  logic [7:0] flags_q;
  logic [7:0] flags_set;
  logic [7:0] flags_clr;
  logic [1:0] full_prev_q;
  logic [1:0] empty_prev_q;
  logic       run;

  // Levels are compared with the previous cycle so only a change counts.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_prev_q  <= '0;
      empty_prev_q <= '1;
    end
    else if (run)
    begin
      full_prev_q  <= fifo_levels.full;
      empty_prev_q <= fifo_levels.empty;
    end
  end

  // While the enable is low nothing may set a flag, freezing the state.
  assign run = controller_clock_enable; // [R14]

  // Set and clear terms for every flag.
  always_comb
  begin
    flags_set = 8'h00;
    flags_clr = 8'h00;
    flags_set[card_host_pkg::BIT_CARD_BUSY]     = run & busy_edge; // [R1]
    flags_set[card_host_pkg::BIT_RESPONSE_DONE] = run & engine_events.response_done; // [R2]
    flags_set[card_host_pkg::BIT_COMMAND_DONE]  = run & engine_events.command_done; // [R3]
    flags_set[card_host_pkg::BIT_FRAME_DONE]    = run & engine_events.frame_done; // [R4]
    flags_clr[card_host_pkg::BIT_CARD_BUSY]     = rd_flags; // [R1]
    flags_clr[card_host_pkg::BIT_RESPONSE_DONE] = rd_flags; // [R2]
    flags_clr[card_host_pkg::BIT_COMMAND_DONE]  = rd_flags; // [R3]
    flags_clr[card_host_pkg::BIT_FRAME_DONE]    = rd_flags; // [R4]
    flags_set[card_host_pkg::BIT_SECOND_FULL]   = run & fifo_levels.full[1] & ~full_prev_q[1]; // [R5]
    flags_clr[card_host_pkg::BIT_SECOND_FULL]   = run & fifo_levels.empty[1] & ~empty_prev_q[1]; // [R5]
    flags_set[card_host_pkg::BIT_FIRST_FULL]    = run & fifo_levels.full[0] & ~full_prev_q[0]; // [R6]
    flags_clr[card_host_pkg::BIT_FIRST_FULL]    = run & fifo_levels.empty[0] & ~empty_prev_q[0]; // [R6]
    flags_set[card_host_pkg::BIT_SECOND_EMPTY]  = run & fifo_levels.empty[1] & ~empty_prev_q[1]; // [R7]
    flags_clr[card_host_pkg::BIT_SECOND_EMPTY]  = run & fifo_levels.full[1] & ~full_prev_q[1]; // [R7]
    flags_set[card_host_pkg::BIT_FIRST_EMPTY]   = run & fifo_levels.empty[0] & ~empty_prev_q[0]; // [R8]
    flags_clr[card_host_pkg::BIT_FIRST_EMPTY]   = run & fifo_levels.full[0] & ~full_prev_q[0]; // [R8]
  end

  // A set in the same cycle as a clear wins, so no event is lost to a read.
  generate
    for (genvar i = 0; i < card_host_pkg::EVENT_COUNT; i++)
    begin : g_flag
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          flags_q[i] <= card_host_pkg::FLAGS_RESET[i];
        else if (flags_set[i])
          flags_q[i] <= 1'b1;
        else if (flags_clr[i])
          flags_q[i] <= 1'b0;
      end
    end
  endgenerate

  // Registered interrupt request, one cycle behind the flags.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      controller_irq <= 1'b0;
    else
      controller_irq <= |(flags_q & ~mask_q); // [R9] [R16]
  end

  // ************************************************************
  // Transmit buffers toward the command and data engines
  // ************************************************************

  // A write while the buffer is full is dropped; software must watch
  // the space output, since the port has no wait state to offer.
  two_entry_buffer #(
    .WIDTH     (DATA_WIDTH),
    .DEPTH     (2)
  ) u_command_buffer (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (sfr_req.wdata),
    .in_valid  (wr_command), // [R10]
    .in_ready  (command_space),
    .out_data  (command_byte),
    .out_valid (command_valid),
    .out_ready (command_ready & run) // [R14]
  );

  // Data bytes queue the same way; the engine stalls by holding ready low.
  two_entry_buffer #(
    .WIDTH     (DATA_WIDTH),
    .DEPTH     (2)
  ) u_data_buffer (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (sfr_req.wdata),
    .in_valid  (wr_data), // [R12]
    .in_ready  (data_space),
    .out_data  (data_byte),
    .out_valid (data_valid),
    .out_ready (data_ready & run) // [R14]
  );

  // ************************************************************
  // Read data and receive pops
  // ************************************************************

  // The command port reads the response FIFO, never the written byte.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata <= card_host_pkg::PORT_RESET;
    else if (rd_command)
      sfr_rdata <= response_byte; // [R11]
    else if (rd_data)
      sfr_rdata <= receive_byte; // [R12]
    else if (rd_flags)
      sfr_rdata <= flags_q;
    else if (sfr_req.rd && sfr_req.addr == card_host_pkg::ADDR_EVENT_MASK)
      sfr_rdata <= mask_q;
    else if (sfr_req.rd && sfr_req.addr == card_host_pkg::ADDR_CLOCK_DIV)
      sfr_rdata <= divider_q;
    else if (sfr_req.rd)
      sfr_rdata <= card_host_pkg::UNMAPPED_READ;
  end

  // Pops go out in the cycle the byte is captured, so the FIFO
  // advances exactly once per read.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      response_pop <= 1'b0;
      receive_pop  <= 1'b0;
    end
    else
    begin
      response_pop <= rd_command; // [R11]
      receive_pop  <= rd_data; // [R12]
    end
  end

  // ************************************************************
  // Card clock divider
  // ************************************************************

  logic [7:0] div_count_q;

  // Half period is divider plus one cycles; a stopped clock rests low.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_count_q <= card_host_pkg::COUNT_ZERO;
      card_clock  <= 1'b0;
    end
    else if (!run)
    begin
      div_count_q <= card_host_pkg::COUNT_ZERO; // [R14]
      card_clock  <= 1'b0;
    end
    else if (div_count_q >= divider_q)
    begin
      div_count_q <= card_host_pkg::COUNT_ZERO; // [R17]
      card_clock  <= ~card_clock; // [R13] [R17]
    end
    else
      div_count_q <= div_count_q + card_host_pkg::COUNT_STEP;
  end

endmodule : card_host_irq_fifo_regs

// ### testbench/card_host_irq_fifo_regs_monitor.sv
/*
  Concurrent checks of the card host register slice.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module card_host_irq_fifo_regs_monitor (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire card_host_pkg::sfr_req_s       sfr_req,
  input wire logic                [7:0]     sfr_rdata,
  input wire logic                          controller_clock_enable,
  input wire logic                          card_busy_pin,
  input wire card_host_pkg::engine_events_s engine_events,
  input wire logic                [7:0]     command_byte,
  input wire logic                          command_valid,
  input wire logic                          command_ready,
  input wire logic                          command_space,
  input wire logic                [7:0]     response_byte,
  input wire logic                          response_pop,
  input wire logic                [7:0]     receive_byte,
  input wire logic                          receive_pop,
  input wire logic                          card_busy_status,
  input wire logic                          card_clock,
  input wire logic                          controller_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // *******************************
  // Shadow mask and decode helpers
  // *******************************
  // The mask is rebuilt from writes, since it is not visible at the ports.
  logic [7:0] mask_q;
  logic       rd_flags;
  logic       en;
  assign rd_flags = sfr_req.rd && sfr_req.addr == 8'he7;
  assign en       = controller_clock_enable;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      mask_q <= 8'hff;
    else if (sfr_req.wr && sfr_req.addr == 8'hdf)
      mask_q <= sfr_req.wdata;

  property p_mask_off; $past(mask_q) == 8'hff |-> !controller_irq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq raised while all masked");
  property p_irq; en && engine_events.frame_done && !mask_q[4] |-> ##2 controller_irq; endproperty
  a_irq: assert property (p_irq) else $error("unmasked event gave no irq");
  property p_ev_set;
    en && engine_events != 3'h0 ##1 rd_flags |=>
      (sfr_rdata[6:4] & $past(engine_events, 2)) == $past(engine_events, 2);
  endproperty
  a_ev_set: assert property (p_ev_set) else $error("event flag not set");
  property p_rd_clr;
    rd_flags && engine_events == 3'h0 ##1 engine_events == 3'h0 ##1 rd_flags && engine_events == 3'h0
      |=> sfr_rdata[6:4] == 3'h0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("flag read did not clear");
  property p_busy; $rose(card_busy_pin) ##1 card_busy_pin [*3] |-> card_busy_status; endproperty
  a_busy: assert property (p_busy) else $error("busy status late");
  property p_cmd;
    sfr_req.wr && sfr_req.addr == 8'hdd && command_space && !command_valid
      |=> command_valid && command_byte == $past(sfr_req.wdata);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command byte not queued");
  property p_hold; command_valid && !command_ready |=> command_valid && $stable(command_byte); endproperty
  a_hold: assert property (p_hold) else $error("command head lost");
  property p_resp; sfr_req.rd && sfr_req.addr == 8'hdd |=> response_pop && sfr_rdata == $past(response_byte); endproperty
  a_resp: assert property (p_resp) else $error("response read wrong");
  property p_recv; sfr_req.rd && sfr_req.addr == 8'hdc |=> receive_pop && sfr_rdata == $past(receive_byte); endproperty
  a_recv: assert property (p_recv) else $error("receive read wrong");
  property p_stop; !en [*2] |-> !card_clock; endproperty
  a_stop: assert property (p_stop) else $error("card clock runs while disabled");
endmodule : card_host_irq_fifo_regs_monitor

// ### testbench/card_engine_model.sv
/*
  Behavioural model of the card line engine behind the slice.
  Assumes the testbench steers its stall input.
*/
`timescale 1ns/1ns
module card_engine_model (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic [7:0] command_byte,
  input  wire logic       command_valid,
  output logic            command_ready,
  input  wire logic [7:0] data_byte,
  input  wire logic       data_valid,
  output logic            data_ready,
  input  wire logic       response_pop,
  output logic      [7:0] response_byte,
  input  wire logic       receive_pop,
  output logic      [7:0] receive_byte
);
  logic [7:0] cmd_seen[$];
  logic [7:0] data_seen[$];

  // Ready follows stall; FIFO heads advance on each pop.
  initial
  begin
    command_ready = 1'b0;
    data_ready    = 1'b0;
    response_byte = 8'h30;
    receive_byte  = 8'h90;
  end
  always @(negedge clk)
  begin
    command_ready <= !stall;
    data_ready    <= !stall;
    if (response_pop)
      response_byte <= response_byte + 8'h01;
    if (receive_pop)
      receive_byte <= receive_byte + 8'h01;
  end
  // Bytes are taken only at an edge where both sides agree.
  always @(posedge clk)
  begin
    if (command_valid && command_ready)
      cmd_seen.push_back(command_byte);
    if (data_valid && data_ready)
      data_seen.push_back(data_byte);
  end
endmodule : card_engine_model

// ### testbench/test_card_host_irq_fifo_regs.sv
/*
  Self-checking bench of the card host register slice.
  Assumes the engine model and the bound monitor.
*/
`timescale 1ns/1ns
module test_card_host_irq_fifo_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic busy = 1'b0;
  logic stall = 1'b0;
  card_host_pkg::sfr_req_s       req = '0;
  card_host_pkg::engine_events_s ev = '0;
  card_host_pkg::fifo_levels_s   lv = 4'h3;
  logic [7:0] sfr_rdata, command_byte, response_byte, data_byte, receive_byte;
  logic command_valid, command_ready, command_space, response_pop, data_valid, data_ready;
  logic data_space, receive_pop, card_busy_status, card_clock, controller_irq;
  int failures = 0;
  int cmp_count = 0;
  int n;

  card_host_irq_fifo_regs DUT (.clk, .rst_n, .sfr_req(req), .sfr_rdata, .controller_clock_enable(en),
    .card_busy_pin(busy), .engine_events(ev), .fifo_levels(lv), .command_byte, .command_valid,
    .command_ready, .command_space, .response_byte, .response_pop, .data_byte, .data_valid, .data_ready,
    .data_space, .receive_byte, .receive_pop, .card_busy_status, .card_clock, .controller_irq);
  card_engine_model eng (.clk, .stall, .command_byte, .command_valid, .command_ready, .data_byte,
    .data_valid, .data_ready, .response_pop, .response_byte, .receive_pop, .receive_byte);

  // *******************************
  // Shared tasks
  // *******************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One register access; inputs move only on falling edges.
  task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge clk);
    req = {a, w, !w, d};
    @(negedge clk);
    req = '0;
  endtask : sfr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr(a, 1'b0, 8'h00);
    check(sfr_rdata, exp);
  endtask : rd_chk
  // Counts falling edges until the card clock changes level.
  task automatic half(output int k);
    logic v;
    v = card_clock;
    k = 0;
    while (card_clock === v && k < 600)
    begin
      @(negedge clk);
      k++;
    end
  endtask : half
  task automatic stop_test;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // *******************************
  // Scenarios
  // *******************************
  task automatic t_reset;
    check(sfr_rdata, 8'hff);
    rd_chk(8'hdf, 8'hff);
    rd_chk(8'hed, 8'h00);
    sfr(8'he7, 1'b1, 8'h5a);
    rd_chk(8'he7, 8'h00);
    rd_chk(8'h80, 8'h00);
  endtask : t_reset
  // Each event alone, unmasked, then the frame event masked, then two
  // events whose flags are read in the very next cycle.
  task automatic t_events;
    for (int i = 0; i < 3; i++)
    begin
      sfr(8'hdf, 1'b1, ~(8'h10 << i));
      @(negedge clk);
      ev = 3'(1 << i);
      @(negedge clk);
      ev = '0;
      @(negedge clk);
      check(8'(controller_irq), 8'h01);
      rd_chk(8'he7, 8'h10 << i);
      rd_chk(8'he7, 8'h00);
      check(8'(controller_irq), 8'h00);
    end
    sfr(8'hdf, 1'b1, 8'hff);
    ev = 3'h1;
    @(negedge clk);
    ev = '0;
    repeat (2) @(negedge clk);
    check(8'(controller_irq), 8'h00);
    rd_chk(8'he7, 8'h10);
    ev = 3'h6;
    @(negedge clk);
    ev  = '0;
    req = {8'he7, 1'b0, 1'b1, 8'h00};
    @(negedge clk);
    req = '0;
    check(sfr_rdata, 8'h60);
  endtask : t_events
  task automatic t_rx;
    rd_chk(8'hdd, 8'h30);
    rd_chk(8'hdd, 8'h31);
    rd_chk(8'hdc, 8'h90);
  endtask : t_rx
  // Fill each transmit buffer past its two entries while stalled.
  task automatic t_tx;
    for (int i = 0; i < 2; i++)
    begin
      stall = 1'b1;
      for (int k = 0; k < 3; k++)
        sfr(i ? 8'hdc : 8'hdd, 1'b1, 8'ha1 + 8'(3 * i + k));
      check(8'(i ? data_space : command_space), 8'h00);
      stall = 1'b0;
      repeat (6) @(negedge clk);
      check(8'(i ? eng.data_seen.size() : eng.cmd_seen.size()), 8'h02);
      check(i ? eng.data_seen[1] : eng.cmd_seen[1], 8'ha2 + 8'(3 * i));
    end
  endtask : t_tx
  task automatic t_busy;
    sfr(8'hdf, 1'b1, 8'h7f);
    busy = 1'b1;
    repeat (5) @(negedge clk);
    check(8'(card_busy_status), 8'h01);
    check(8'(controller_irq), 8'h01);
    rd_chk(8'he7, 8'h80);
    rd_chk(8'he7, 8'h00);
    busy = 1'b0;
    repeat (5) @(negedge clk);
    check(8'(card_busy_status), 8'h00);
    rd_chk(8'he7, 8'h80);
    sfr(8'hdf, 1'b1, 8'hff);
  endtask : t_busy
  // Half period is the divider plus one; a stopped controller freezes flags.
  task automatic t_clock;
    sfr(8'hed, 1'b1, 8'h02);
    half(n);
    half(n);
    check(8'(n), 8'h03);
    sfr(8'hed, 1'b1, 8'h05);
    half(n);
    half(n);
    check(8'(n), 8'h06);
    en = 1'b0;
    ev = 3'h4;
    @(negedge clk);
    ev = '0;
    @(negedge clk);
    check(8'(card_clock), 8'h00);
    rd_chk(8'he7, 8'h00);
    en = 1'b1;
  endtask : t_clock
  task automatic t_fifo;
    lv = 4'hc;
    repeat (2) @(negedge clk);
    rd_chk(8'he7, 8'h0c);
    rd_chk(8'he7, 8'h0c);
    lv = 4'h3;
    repeat (2) @(negedge clk);
    rd_chk(8'he7, 8'h03);
    lv = 4'hc;
    repeat (2) @(negedge clk);
    rd_chk(8'he7, 8'h0c);
  endtask : t_fifo

  // Clock, watchdog and main sequence.
  initial
    forever #4 clk = ~clk;
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial
  begin
    n = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    en = 1'b1;
    t_reset();
    t_events();
    t_rx();
    t_tx();
    t_busy();
    t_clock();
    t_fifo();
    stop_test();
  end
endmodule : test_card_host_irq_fifo_regs

bind card_host_irq_fifo_regs card_host_irq_fifo_regs_monitor u_mon (.clk, .rst_n, .sfr_req, .sfr_rdata,
  .controller_clock_enable, .card_busy_pin, .engine_events, .command_byte, .command_valid, .command_ready,
  .command_space, .response_byte, .response_pop, .receive_byte, .receive_pop, .card_busy_status,
  .card_clock, .controller_irq);
